/* File: core/lesc_corr_event.sv */
// correctable event decode from link layer status
module lesc_corr_event (
	input wire lesc_pkg::lesc_link_events_t events,
	output logic [31:0] raw_events
);
	always_comb begin
		raw_events = 32'h00000000;
		raw_events[lesc_pkg::RETRY_TIMER_BIT] =
			events.retry_timer_expired;
		raw_events[lesc_pkg::RETRY_ROLL_BIT] =
			events.retry_count_wrapped;
		raw_events[lesc_pkg::LINK_DECODE_BIT] = events.phy_decode_error &
			events.rx_link_packet;
		raw_events[lesc_pkg::TRANS_DECODE_BIT] = events.phy_decode_error &
			events.rx_transaction_packet;
		raw_events[lesc_pkg::RX_ERROR_BIT] = events.phy_decode_error;
	end
endmodule

/* File: core/lesc_pkg.sv */
// package: offsets, field layout, reset values and carrier structs
package lesc_pkg;
	localparam logic [11:0] SEVERITY_OFFSET = 12'h10c;
	localparam logic [11:0] CORR_STATUS_OFFSET = 12'h110;
	localparam logic [11:0] CORR_MASK_OFFSET = 12'h114;
	localparam logic [31:0] SEVERITY_RESET = 32'h00062011;
	localparam logic [31:0] SEVERITY_RW_BITS = 32'h001ff010;
	localparam logic [31:0] SEVERITY_RO_ONES = 32'h00000001;
	localparam logic [31:0] CORR_STATUS_RESET = 32'h00000000;
	localparam logic [31:0] CORR_MASK_RESET = 32'h00000000;
	localparam logic [31:0] CORR_IMPL_BITS = 32'h000011c1;
	localparam int RX_ERROR_BIT = 0;
	localparam int TRANS_DECODE_BIT = 6;
	localparam int LINK_DECODE_BIT = 7;
	localparam int RETRY_ROLL_BIT = 8;
	localparam int RETRY_TIMER_BIT = 12;
	localparam int UNCORR_CLASSES = 21;
	localparam logic [4:0] FIRST_PTR_RESET = 5'h00;

	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] offset;
		logic [31:0] wdata;
	} lesc_cfg_req_t;

	typedef struct packed {
		logic retry_timer_expired;
		logic retry_count_wrapped;
		logic phy_decode_error;
		logic rx_link_packet;
		logic rx_transaction_packet;
	} lesc_link_events_t;

	typedef enum logic [1:0] {
		LESC_MSG_CORRECTABLE,
		LESC_MSG_NONFATAL,
		LESC_MSG_FATAL
	} lesc_msg_kind_t;
endpackage

/* File: core/lesc_severity_map.sv */
// maps an uncorrectable class to fatal or nonfatal message kind
module lesc_severity_map #(
	parameter int CLASSES = 21
) (
	input wire [CLASSES-1:0] severity,
	input wire [CLASSES-1:0] uncorr_event,
	output logic fatal_event,
	output logic nonfatal_event
);
	assign fatal_event = |(uncorr_event & severity);
	assign nonfatal_event = |(uncorr_event & ~severity);
endmodule

/* File: core/lesc_top.sv */
// severity and correctable error register bank with message requests
module lesc_top #(
	parameter int CLASSES = lesc_pkg::UNCORR_CLASSES
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire fundamental_reset,
	input wire global_reset_input,
	input wire power_on_reset,
	input wire lesc_pkg::lesc_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire lesc_pkg::lesc_link_events_t link_events,
	input wire [CLASSES-1:0] uncorr_event,
	input wire [CLASSES-1:0] uncorr_mask,
	output logic msg_valid,
	output lesc_pkg::lesc_msg_kind_t msg_kind,
	input wire msg_ready,
	output logic log_load,
	output logic [4:0] first_error_ptr
);
	logic any_rst;
	logic [31:0] sev_q;
	logic [31:0] status_q;
	logic [31:0] mask_q;
	logic [31:0] raw_events;
	logic [31:0] corr_hits;
	logic [CLASSES-1:0] uncorr_hits;
	logic fatal_event;
	logic nonfatal_event;
	logic pend_corr_q;
	logic pend_nonfatal_q;
	logic pend_fatal_q;
	logic ptr_valid_q;
	logic [4:0] ptr_q;
	logic wr_sev;
	logic wr_status;
	logic wr_mask;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		return cfg_req.valid && cfg_req.write && a == b;
	endfunction

	function automatic logic [4:0] lowest(input logic [CLASSES-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = CLASSES - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// any of the four reset sources restores every default
	assign any_rst = sys_rst | fundamental_reset | global_reset_input |
		power_on_reset;
	assign wr_sev = hit(cfg_req.offset, lesc_pkg::SEVERITY_OFFSET);
	assign wr_status = hit(cfg_req.offset, lesc_pkg::CORR_STATUS_OFFSET);
	assign wr_mask = hit(cfg_req.offset, lesc_pkg::CORR_MASK_OFFSET);

	lesc_corr_event u_event (
		.events(link_events),
		.raw_events(raw_events)
	);

	lesc_severity_map #(.CLASSES(CLASSES)) u_sev (
		.severity(sev_q[CLASSES-1:0]),
		.uncorr_event(uncorr_hits),
		.fatal_event(fatal_event),
		.nonfatal_event(nonfatal_event)
	);

	// masked events never reach status, messages, log or pointer
	assign corr_hits = raw_events & ~mask_q &
		lesc_pkg::CORR_IMPL_BITS;
	assign uncorr_hits = uncorr_event & ~uncorr_mask;

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			sev_q <= lesc_pkg::SEVERITY_RESET;
		end else if (wr_sev) begin
			// only listed severity bits move; bit 0 pinned high
			sev_q <= (cfg_req.wdata & lesc_pkg::SEVERITY_RW_BITS) |
				lesc_pkg::SEVERITY_RO_ONES;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			mask_q <= lesc_pkg::CORR_MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= cfg_req.wdata & lesc_pkg::CORR_IMPL_BITS;
		end
	end

	// set wins over a same-cycle clear so no event is lost
	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			status_q <= lesc_pkg::CORR_STATUS_RESET;
		end else if (wr_status) begin
			status_q <= ((status_q & ~cfg_req.wdata) | corr_hits) &
				lesc_pkg::CORR_IMPL_BITS;
		end else begin
			status_q <= status_q | corr_hits;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			ptr_valid_q <= 1'b0;
			ptr_q <= lesc_pkg::FIRST_PTR_RESET;
		end else if (!ptr_valid_q && |uncorr_hits) begin
			ptr_valid_q <= 1'b1;
			ptr_q <= lowest(uncorr_hits);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			log_load <= 1'b0;
		end else begin
			log_load <= |uncorr_hits;
		end
	end

	// one pending flag per message kind; fatal drains first
	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			pend_corr_q <= 1'b0;
			pend_nonfatal_q <= 1'b0;
			pend_fatal_q <= 1'b0;
		end else begin
			pend_fatal_q <= fatal_event | (pend_fatal_q &
				!(msg_ready && msg_kind == lesc_pkg::LESC_MSG_FATAL));
			pend_nonfatal_q <= nonfatal_event | (pend_nonfatal_q &
				!(msg_ready && msg_kind == lesc_pkg::LESC_MSG_NONFATAL));
			pend_corr_q <= (|corr_hits) | (pend_corr_q &
				!(msg_ready && msg_kind ==
				lesc_pkg::LESC_MSG_CORRECTABLE));
		end
	end

	assign msg_valid = pend_fatal_q | pend_nonfatal_q | pend_corr_q;
	always_comb begin
		if (pend_fatal_q) begin
			msg_kind = lesc_pkg::LESC_MSG_FATAL;
		end else if (pend_nonfatal_q) begin
			msg_kind = lesc_pkg::LESC_MSG_NONFATAL;
		end else begin
			msg_kind = lesc_pkg::LESC_MSG_CORRECTABLE;
		end
	end

	assign first_error_ptr = ptr_q;

	// reads are answered the cycle after the request, from flops
	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_req.valid;
			unique case (cfg_req.offset)
				lesc_pkg::SEVERITY_OFFSET: cfg_rdata <= sev_q;
				lesc_pkg::CORR_STATUS_OFFSET: cfg_rdata <= status_q;
				lesc_pkg::CORR_MASK_OFFSET: cfg_rdata <= mask_q;
				default: cfg_rdata <= 32'h00000000;
			endcase
		end
	end

	property p_sev_fixed;
		@(posedge ref_clk) disable iff (any_rst)
		sev_q[0] && (sev_q & ~(lesc_pkg::SEVERITY_RW_BITS |
			lesc_pkg::SEVERITY_RO_ONES)) == 32'h00000000;
	endproperty
	a_sev_fixed: assert property (p_sev_fixed)
		else $error("severity reserved bits wrong");

	property p_sev_reset;
		@(posedge ref_clk) $past(any_rst) |-> sev_q == 32'h00062011;
	endproperty
	a_sev_reset: assert property (p_sev_reset)
		else $error("severity reset value wrong");

	property p_status_reserved;
		@(posedge ref_clk) disable iff (any_rst)
		(status_q & ~32'h000011c1) == 32'h00000000 &&
		(mask_q & ~32'h000011c1) == 32'h00000000;
	endproperty
	a_status_reserved: assert property (p_status_reserved)
		else $error("reserved correctable bit set");

	property p_no_self_clear;
		@(posedge ref_clk) disable iff (any_rst)
		!wr_status |=> (status_q & $past(status_q)) == $past(status_q);
	endproperty
	a_no_self_clear: assert property (p_no_self_clear)
		else $error("status bit cleared without write");

	property p_rx_error_set;
		@(posedge ref_clk) disable iff (any_rst)
		link_events.phy_decode_error && !mask_q[0] |=> status_q[0];
	endproperty
	a_rx_error_set: assert property (p_rx_error_set)
		else $error("receiver error not recorded");

	property p_transaction_packet_decode_error;
		@(posedge ref_clk) disable iff (any_rst)
		link_events.phy_decode_error && link_events.rx_transaction_packet &&
		!mask_q[6] |=> status_q[6];
	endproperty
	a_transaction_packet_decode_error: assert property (p_transaction_packet_decode_error)
		else $error("bad transaction packet not recorded");

	property p_masked_quiet;
		@(posedge ref_clk) disable iff (any_rst)
		mask_q[12] && !status_q[12] && !wr_mask |=> !status_q[12];
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("masked status bit set");

	sequence s_timer_unmasked;
		link_events.retry_timer_expired && !mask_q[12];
	endsequence
	property p_timer_msg;
		@(posedge ref_clk) disable iff (any_rst)
		s_timer_unmasked |=> status_q[12] && msg_valid;
	endproperty
	a_timer_msg: assert property (p_timer_msg)
		else $error("retry timer event lost");

	property p_fatal_kind;
		@(posedge ref_clk) disable iff (any_rst)
		fatal_event |=> msg_valid && msg_kind == lesc_pkg::LESC_MSG_FATAL;
	endproperty
	a_fatal_kind: assert property (p_fatal_kind)
		else $error("fatal error not reported as fatal");

	property p_nonfatal_kind;
		@(posedge ref_clk) disable iff (any_rst)
		nonfatal_event && !fatal_event && !pend_fatal_q |=>
		msg_valid && msg_kind == lesc_pkg::LESC_MSG_NONFATAL;
	endproperty
	a_nonfatal_kind: assert property (p_nonfatal_kind)
		else $error("nonfatal error not reported as nonfatal");

	property p_ack_follows;
		@(posedge ref_clk) disable iff (any_rst)
		cfg_req.valid |=> cfg_ack;
	endproperty
	a_ack_follows: assert property (p_ack_follows)
		else $error("configuration access not acknowledged");

	property p_retry_wrap;
		@(posedge ref_clk) disable iff (any_rst)
		link_events.retry_count_wrapped && !mask_q[8] |=> status_q[8];
	endproperty
	a_retry_wrap: assert property (p_retry_wrap)
		else $error("retry counter wrap not recorded");

	property p_bad_link_packet;
		@(posedge ref_clk) disable iff (any_rst)
		link_events.phy_decode_error && link_events.rx_link_packet &&
		!mask_q[7] |=> status_q[7];
	endproperty
	a_bad_link_packet: assert property (p_bad_link_packet)
		else $error("bad link packet not recorded");

	// a same-cycle event may legally keep its bit, so only quiet cycles count
	property p_status_clear;
		@(posedge ref_clk) disable iff (any_rst)
		wr_status && corr_hits == 32'h00000000 |=>
		(status_q & $past(cfg_req.wdata)) == 32'h00000000;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status bit not cleared by write of one");

	property p_ptr_hold;
		@(posedge ref_clk) disable iff (any_rst)
		ptr_valid_q |=> ptr_q == $past(ptr_q);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold)
		else $error("first error pointer moved");

	property p_log_quiet;
		@(posedge ref_clk) disable iff (any_rst)
		uncorr_hits == '0 |=> !log_load;
	endproperty
	a_log_quiet: assert property (p_log_quiet)
		else $error("header log loaded without unmasked error");
endmodule

/* File: tb/lesc_host_model.sv */
// host side message sink, prompt or slow in taking messages
module lesc_host_model (
	input wire ref_clk,
	input wire sys_rst,
	input wire slow,
	input wire msg_valid,
	output logic msg_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic toggle_q;
	always_ff @(posedge ref_clk) begin
		toggle_q <= sys_rst ? 1'b0 : ~toggle_q;
	end
	// slow mode stalls every other cycle so a message waits pending
	assign msg_ready = !slow || toggle_q;
endmodule

/* File: tb/test_lesc_top.sv */
// self-checking bench for the severity and correctable error bank
module test_lesc_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] rst_alt = 3'h0;
	logic slow = 1'b0;
	lesc_pkg::lesc_cfg_req_t cfg_req = '0;
	lesc_pkg::lesc_link_events_t link_events = '0;
	logic [20:0] uncorr_event = 21'h0;
	logic [20:0] uncorr_mask = 21'h0;
	logic [31:0] cfg_rdata;
	logic cfg_ack;
	logic msg_valid;
	logic msg_ready;
	logic log_load;
	lesc_pkg::lesc_msg_kind_t msg_kind;
	logic [4:0] first_error_ptr;
	logic [31:0] rd;
	int mismatches = 0;
	int n_tests = 0;
	logic [4:0] evs [5] = '{5'h10, 5'h08, 5'h06, 5'h05, 5'h04};
	logic [31:0] sts [5] = '{32'h1000, 32'h100, 32'h81, 32'h41, 32'h1};
	always #5 ref_clk = ~ref_clk;
	lesc_top DUT (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.fundamental_reset(rst_alt[0]),
		.global_reset_input(rst_alt[1]),
		.power_on_reset(rst_alt[2]),
		.cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack),
		.link_events(link_events),
		.uncorr_event(uncorr_event),
		.uncorr_mask(uncorr_mask),
		.msg_valid(msg_valid),
		.msg_kind(msg_kind),
		.msg_ready(msg_ready),
		.log_load(log_load),
		.first_error_ptr(first_error_ptr)
	);
	lesc_host_model host (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.slow(slow),
		.msg_valid(msg_valid),
		.msg_ready(msg_ready)
	);
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one request, then a bounded wait for the acknowledge
	task automatic cfg(logic wr, logic [11:0] off, logic [31:0] wd);
		int i;
		@(posedge ref_clk);
		cfg_req <= '{1'b1, wr, off, wd};
		@(posedge ref_clk);
		cfg_req.valid <= 1'b0;
		#1;
		for (i = 0; i < 4; i++) begin
			if (cfg_ack === 1'b1)
				break;
			@(posedge ref_clk);
			#1;
		end
		if (i == 4) begin
			mismatches++;
			close_out();
		end else begin
			rd = cfg_rdata;
		end
	endtask
	task automatic rdc(logic [11:0] off, logic [31:0] exp, string name);
		cfg(1'b0, off, 32'h0);
		check(name, rd, exp);
	endtask
	task automatic pulse(logic [4:0] ev);
		@(posedge ref_clk);
		link_events <= ev;
		@(posedge ref_clk);
		link_events <= '0;
		#1;
	endtask
	task automatic upulse(logic [20:0] ev, logic [20:0] m);
		@(posedge ref_clk);
		uncorr_event <= ev;
		uncorr_mask <= m;
		@(posedge ref_clk);
		uncorr_event <= 21'h0;
		#1;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc(12'h10c, 32'h00062011, "severity reset");
		rdc(12'h110, 32'h0, "status reset");
		rdc(12'h114, 32'h0, "mask reset");
		rdc(12'h118, 32'h0, "unmapped");
		cfg(1'b1, 12'h10c, 32'hffffffff);
		rdc(12'h10c, 32'h001ff011, "severity ones");
		cfg(1'b1, 12'h10c, 32'h0);
		rdc(12'h10c, 32'h00000001, "severity zeros");
		cfg(1'b1, 12'h10c, 32'h00062011);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			pulse(evs[i]);
			check("corr message", 32'({msg_valid, msg_kind}), 32'h4);
			rdc(12'h110, sts[i], "status set");
			cfg(1'b1, 12'h110, ~sts[i]);
			rdc(12'h110, sts[i], "status kept");
			cfg(1'b1, 12'h110, sts[i]);
			rdc(12'h110, 32'h0, "status cleared");
		end
		$display("test status done");
		cfg(1'b1, 12'h114, 32'hffffffff);
		rdc(12'h114, 32'h000011c1, "mask bits");
		for (int i = 0; i < 5; i++) begin
			pulse(evs[i]);
			check("masked message", 32'(msg_valid), 32'h0);
		end
		rdc(12'h110, 32'h0, "masked status");
		cfg(1'b1, 12'h114, 32'h0);
		$display("test mask done");
		slow <= 1'b1;
		upulse(21'h100000, 21'h0);
		check("nonfatal", 32'({msg_valid, msg_kind}), 32'h5);
		check("log load", 32'(log_load), 32'h1);
		upulse(21'h040000, 21'h0);
		check("fatal", 32'({msg_valid, msg_kind}), 32'h6);
		upulse(21'h000010, 21'h000010);
		check("masked log", 32'(log_load), 32'h0);
		check("first pointer", 32'(first_error_ptr), 32'h14);
		slow <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		check("messages drained", 32'(msg_valid), 32'h0);
		$display("test messages done");
		for (int i = 0; i < 3; i++) begin
			cfg(1'b1, 12'h10c, 32'h0);
			pulse(5'h04);
			cfg(1'b1, 12'h114, 32'hffffffff);
			@(posedge ref_clk);
			rst_alt <= 3'h1 << i;
			@(posedge ref_clk);
			rst_alt <= 3'h0;
			rdc(12'h10c, 32'h00062011, "severity after reset");
			rdc(12'h110, 32'h0, "status after reset");
			rdc(12'h114, 32'h0, "mask after reset");
			check("pointer after reset", 32'(first_error_ptr), 32'h0);
		end
		$display("test resets done");
		close_out();
	end
endmodule
